// ===== shared/caid_map.vh
// Opcode, special register, flag and timing constants of the arithmetic core
`ifndef CAID_MAP_VH
`define CAID_MAP_VH

// Opcode groups, upper nibble
`define CAID_HI_INC        4'h0
`define CAID_HI_DEC        4'h1
`define CAID_HI_ADD        4'h2
`define CAID_HI_SUM_WITH_CARRY       4'h3
`define CAID_HI_DIFFERENCE_WITH_BORROW       4'h9

// Operand forms, lower nibble
`define CAID_LO_ACC_IMM    4'h4
`define CAID_LO_DIRECT     4'h5

// Single opcodes
`define CAID_OP_INC_PTR    8'hA3
`define CAID_OP_MUL        8'hA4
`define CAID_OP_DIV        8'h84
`define CAID_OP_DA         8'hD4
`define CAID_OP_MOVC_PTR   8'h93

// Arithmetic unit operations
`define CAID_ALU_ADD       3'h0
`define CAID_ALU_SUM_WITH_CARRY      3'h1
`define CAID_ALU_DIFFERENCE_WITH_BORROW      3'h2
`define CAID_ALU_INC       3'h3
`define CAID_ALU_DEC       3'h4
`define CAID_ALU_MUL       3'h5
`define CAID_ALU_DIV       3'h6
`define CAID_ALU_DA        3'h7

// Special register direct addresses
`define CAID_SFR_BASE      8'h80
`define CAID_SFR_PTR_LO    8'h82
`define CAID_SFR_PTR_HI    8'h83
`define CAID_SFR_PSW       8'hD0
`define CAID_SFR_ACC       8'hE0
`define CAID_SFR_B         8'hF0
`define CAID_BIT_RAM_BASE  8'h20

// Status word bit positions
`define CAID_PSW_CY        7
`define CAID_PSW_AC        6
`define CAID_PSW_RS_HI     4
`define CAID_PSW_RS_LO     3
`define CAID_PSW_OV        2
`define CAID_PSW_RESET     8'h00

// Byte lengths and cycle counts
`define CAID_LEN_1         2'h1
`define CAID_LEN_2         2'h2
`define CAID_CYC_1         3'h1
`define CAID_CYC_2         3'h2
`define CAID_CYC_3         3'h3
`define CAID_CYC_5         3'h5
`define CAID_CYC_6         3'h6

`endif

// ===== core/caid_iram.v
// Internal data RAM, one write and three read ports
`timescale 1ns/1ns
`default_nettype none
module caid_iram (
    input  wire        ref_clk,
    input  wire        we,
    input  wire [7:0]  waddr,
    input  wire [7:0]  wdata,
    input  wire [23:0] raddr,
    output wire [23:0] rdata
);
    reg [7:0] mem [0:255];
    genvar g;

    always @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // One asynchronous read port per 8-bit field of raddr, three in all
    generate
        for (g = 0; g < 3; g = g + 1) begin : g_rd
            assign rdata[g*8 +: 8] = mem[raddr[g*8 +: 8]];
        end
    endgenerate
endmodule // caid_iram
`default_nettype wire

// ===== core/caid_alu.v
// Arithmetic unit for the accumulator instructions
`timescale 1ns/1ns
`default_nettype none
`include "caid_map.vh"
module caid_alu (
    input  wire [2:0] op,
    input  wire [7:0] a,
    input  wire [7:0] src,
    input  wire [7:0] b,
    input  wire       cy_in,
    input  wire       ac_in,
    output reg  [7:0] res,
    output reg  [7:0] res_b,
    output reg        cy,
    output reg        ac,
    output reg        ov
);
    reg [8:0]  sum;
    reg [4:0]  nib;
    reg [15:0] prod;
    reg [8:0]  adj;

    always @* begin
        sum   = 9'h000;
        nib   = 5'h00;
        prod  = 16'h0000;
        adj   = 9'h000;
        res   = a;
        res_b = b;
        cy    = cy_in;
        ac    = ac_in;
        ov    = 1'b0;
        case (op)
            `CAID_ALU_ADD, `CAID_ALU_SUM_WITH_CARRY: begin
                sum = {1'b0, a} + {1'b0, src} + {8'h00, (op == `CAID_ALU_SUM_WITH_CARRY) & cy_in};
                nib = {1'b0, a[3:0]} + {1'b0, src[3:0]} + {4'h0, (op == `CAID_ALU_SUM_WITH_CARRY) & cy_in};
                res = sum[7:0];
                cy  = sum[8];
                ac  = nib[4];
                ov  = (a[7] == src[7]) && (sum[7] != a[7]);
            end
            `CAID_ALU_DIFFERENCE_WITH_BORROW: begin
                sum = {1'b0, a} - {1'b0, src} - {8'h00, cy_in};
                nib = {1'b0, a[3:0]} - {1'b0, src[3:0]} - {4'h0, cy_in};
                res = sum[7:0];
                cy  = sum[8];
                ac  = nib[4];
                ov  = (a[7] != src[7]) && (sum[7] != a[7]);
            end
            `CAID_ALU_INC: res = src + 8'h01;
            `CAID_ALU_DEC: res = src - 8'h01;
            `CAID_ALU_MUL: begin
                prod  = a * b;
                res   = prod[7:0];
                res_b = prod[15:8];
                cy    = 1'b0;
                ov    = (prod[15:8] != 8'h00);
            end
            `CAID_ALU_DIV: begin
                cy = 1'b0;
                if (b == 8'h00) begin
                    ov = 1'b1;
                end else begin
                    res   = a / b;
                    res_b = a % b;
                end
            end
            default: begin
                adj = {1'b0, a};
                if ((a[3:0] > 4'h9) || ac_in) begin
                    adj = adj + 9'h006;
                end
                if ((adj[7:4] > 4'h9) || adj[8] || cy_in) begin
                    adj = adj + 9'h060;
                end
                res = adj[7:0];
                cy  = cy_in | adj[8];
            end
        endcase
    end
endmodule // caid_alu
`default_nettype wire

// ===== core/caid_core.v
// Arithmetic instruction decode and execute with operand addressing
// Functional notes
// - Direct mode uses an 8-bit address field, reaching RAM and special registers only.
// - Indirect 8-bit address comes from pointer register 0 or 1.
// - Bank register number comes from opcode bits, within the selected bank.
// - Register specific forms act on an implied register like the accumulator.
// - Immediate forms take the operand from the instruction bytes.
// - Indexed mode reads program memory only, at 16-bit pointer plus accumulator.
// - Bit mode picks one bit from a 256-bit bit space.
// - Add: register 1/1, direct or immediate 2/2, indirect 1/2 bytes/cycles.
// - Add with carry adds carry flag too, same lengths and cycles.
// - Subtract with borrow: register 1/1, direct, immediate 2/2, indirect 1/2.
// - Increment: accumulator 1/1, register 1/2, direct 2/3, indirect 1/3.
// - Decrement: accumulator 1/1, register 1/2, direct 2/3, indirect 1/3.
// - Pointer increment is one byte and one cycle.
// - Multiply accumulator by second operand register: one byte, two cycles.
// - Divide accumulator by second operand register: one byte, six cycles.
// - Decimal adjust of accumulator: one byte, three cycles.
`timescale 1ns/1ns
`default_nettype none
`include "caid_map.vh"
module caid_core (
    input  wire        ref_clk,
    input  wire        rst_n,
    input  wire        instr_valid,
    input  wire [7:0]  instr_opcode,
    input  wire [7:0]  instr_operand,
    input  wire        ld_we,
    input  wire [7:0]  ld_addr,
    input  wire [7:0]  ld_data,
    input  wire [7:0]  code_rdata,
    input  wire [7:0]  bit_addr,
    output reg         busy,
    output reg         done,
    output reg         illegal,
    output reg  [1:0]  instr_bytes,
    output reg  [2:0]  instr_cycles,
    output reg  [7:0]  acc,
    output reg  [7:0]  second_operand_reg,
    output reg  [7:0]  psw,
    output reg  [15:0] sixteen_bit_pointer,
    output reg  [15:0] code_addr,
    output reg         code_rd,
    output reg         bit_val
);
    localparam K_NONE = 3'h0;
    localparam K_ACC  = 3'h1;
    localparam K_STEP = 3'h2;
    localparam K_INCP = 3'h3;
    localparam K_MOVC = 3'h4;
    localparam K_B    = 3'h5;

    reg  [7:0]  op_q;
    reg  [7:0]  opnd_q;
    reg  [2:0]  kind_q;
    reg  [2:0]  alu_op_q;
    reg  [2:0]  cnt;
    reg  [2:0]  d_kind;
    reg  [2:0]  d_alu;
    reg  [1:0]  d_len;
    reg  [2:0]  d_cyc;
    reg  [7:0]  src;
    reg  [7:0]  eff_addr;
    reg         eff_ram;
    reg  [7:0]  wr_data;
    reg         ram_we;
    reg  [7:0]  bit_byte;
    wire [3:0]  lo = op_q[3:0];
    wire [3:0]  d_lo = instr_opcode[3:0];
    wire [3:0]  d_hi = instr_opcode[7:4];
    wire [7:0]  rn_addr = {3'h0, psw[`CAID_PSW_RS_HI:`CAID_PSW_RS_LO], op_q[2:0]};
    wire [7:0]  ri_addr = {3'h0, psw[`CAID_PSW_RS_HI:`CAID_PSW_RS_LO], 2'h0, op_q[0]};
    wire [7:0]  bit_ram = `CAID_BIT_RAM_BASE + {4'h0, bit_addr[6:3]};
    wire [23:0] rd_addr = {bit_ram, ri_addr, eff_addr};
    wire [23:0] rd_data;
    wire [7:0]  ptr_val = rd_data[15:8];
    wire [7:0]  res;
    wire [7:0]  res_b;
    wire        f_cy;
    wire        f_ac;
    wire        f_ov;
    wire        take = instr_valid & ~busy;
    wire        last = busy & (cnt == 3'h1);
    wire        ld_go = ld_we & ~busy;

    // Special register read by direct address
    function [7:0] sfr_rd;
        input [7:0]  a;
        input [7:0]  va;
        input [7:0]  vb;
        input [7:0]  vp;
        input [15:0] vd;
        begin
            case (a)
                `CAID_SFR_ACC:    sfr_rd = va;
                `CAID_SFR_B:      sfr_rd = vb;
                `CAID_SFR_PSW:    sfr_rd = vp;
                `CAID_SFR_PTR_LO: sfr_rd = vd[7:0];
                `CAID_SFR_PTR_HI: sfr_rd = vd[15:8];
                default:          sfr_rd = 8'h00;
            endcase
        end
    endfunction

    caid_iram u_iram (
        .ref_clk (ref_clk),
        .we      (ram_we),
        .waddr   (last ? eff_addr : ld_addr),
        .wdata   (wr_data),
        .raddr   (rd_addr),
        .rdata   (rd_data)
    );

    caid_alu u_alu (
        .op    (alu_op_q),
        .a     (acc),
        .src   (src),
        .b     (second_operand_reg),
        .cy_in (psw[`CAID_PSW_CY]),
        .ac_in (psw[`CAID_PSW_AC]),
        .res   (res),
        .res_b (res_b),
        .cy    (f_cy),
        .ac    (f_ac),
        .ov    (f_ov)
    );

    // Decode kind, length and cycles
    always @* begin
        d_kind = K_NONE;
        d_alu  = `CAID_ALU_ADD;
        d_len  = `CAID_LEN_1;
        d_cyc  = `CAID_CYC_1;
        if ((d_hi == `CAID_HI_ADD || d_hi == `CAID_HI_SUM_WITH_CARRY || d_hi == `CAID_HI_DIFFERENCE_WITH_BORROW)
            && d_lo >= `CAID_LO_ACC_IMM) begin
            d_kind = K_ACC;
            d_alu  = (d_hi == `CAID_HI_ADD) ? `CAID_ALU_ADD :
                     (d_hi == `CAID_HI_SUM_WITH_CARRY) ? `CAID_ALU_SUM_WITH_CARRY : `CAID_ALU_DIFFERENCE_WITH_BORROW;
            if (d_lo[3]) begin
                d_cyc = `CAID_CYC_1;
            end else if (d_lo[3:1] == 3'h2) begin
                d_len = `CAID_LEN_2;
                d_cyc = `CAID_CYC_2;
            end else begin
                d_cyc = `CAID_CYC_2;
            end
        end else if ((d_hi == `CAID_HI_INC || d_hi == `CAID_HI_DEC)
            && d_lo >= `CAID_LO_ACC_IMM) begin
            d_kind = K_STEP;
            d_alu  = (d_hi == `CAID_HI_INC) ? `CAID_ALU_INC : `CAID_ALU_DEC;
            if (d_lo == `CAID_LO_ACC_IMM) begin
                d_cyc = `CAID_CYC_1;
            end else if (d_lo[3]) begin
                d_cyc = `CAID_CYC_2;
            end else if (d_lo == `CAID_LO_DIRECT) begin
                d_len = `CAID_LEN_2;
                d_cyc = `CAID_CYC_3;
            end else begin
                d_cyc = `CAID_CYC_3;
            end
        end else begin
            case (instr_opcode)
                `CAID_OP_INC_PTR: d_kind = K_INCP;
                `CAID_OP_MUL: begin
                    d_kind = K_B;
                    d_alu  = `CAID_ALU_MUL;
                    d_cyc  = `CAID_CYC_2;
                end
                `CAID_OP_DIV: begin
                    d_kind = K_B;
                    d_alu  = `CAID_ALU_DIV;
                    d_cyc  = `CAID_CYC_6;
                end
                `CAID_OP_DA: begin
                    d_kind = K_ACC;
                    d_alu  = `CAID_ALU_DA;
                    d_cyc  = `CAID_CYC_3;
                end
                `CAID_OP_MOVC_PTR: begin
                    d_kind = K_MOVC;
                    d_cyc  = `CAID_CYC_5;
                end
                default: d_kind = K_NONE;
            endcase
        end
    end

    // Operand address and source
    always @* begin
        eff_addr = opnd_q;
        eff_ram  = 1'b1;
        src      = opnd_q;
        if (lo[3]) begin
            eff_addr = rn_addr;
            src      = rd_data[7:0];
        end else if (lo == `CAID_LO_DIRECT) begin
            eff_addr = opnd_q;
            eff_ram  = (opnd_q < `CAID_SFR_BASE);
            src      = eff_ram ? rd_data[7:0] :
                       sfr_rd(opnd_q, acc, second_operand_reg, psw, sixteen_bit_pointer);
        end else if (lo[3:1] == 3'h3) begin
            eff_addr = ptr_val;
            src      = rd_data[7:0];
        end else if (kind_q == K_STEP) begin
            eff_ram = 1'b0;
            src     = acc;
        end
    end

    // RAM write: result or loader data
    always @* begin
        ram_we  = 1'b0;
        wr_data = ld_data;
        if (last && kind_q == K_STEP && eff_ram && lo != `CAID_LO_ACC_IMM) begin
            ram_we  = 1'b1;
            wr_data = res;
        end else if (ld_go && ld_addr < `CAID_SFR_BASE) begin
            ram_we = 1'b1;
        end
    end

    // Bit operand from RAM bytes or special registers
    always @* begin
        if (bit_addr < `CAID_SFR_BASE) begin
            bit_byte = rd_data[23:16];
        end else begin
            bit_byte = sfr_rd({bit_addr[7:3], 3'h0}, acc, second_operand_reg, psw,
                              sixteen_bit_pointer);
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy                <= 1'b0;
            done                <= 1'b0;
            illegal             <= 1'b0;
            instr_bytes         <= 2'h0;
            instr_cycles        <= 3'h0;
            acc                 <= 8'h00;
            second_operand_reg  <= 8'h00;
            psw                 <= `CAID_PSW_RESET;
            sixteen_bit_pointer <= 16'h0000;
            code_addr           <= 16'h0000;
            code_rd             <= 1'b0;
            bit_val             <= 1'b0;
            op_q                <= 8'h00;
            opnd_q              <= 8'h00;
            kind_q              <= K_NONE;
            alu_op_q            <= `CAID_ALU_ADD;
            cnt                 <= 3'h0;
        end else begin
            done    <= 1'b0;
            code_rd <= 1'b0;
            bit_val <= bit_byte[bit_addr[2:0]];
            if (take) begin
                busy         <= 1'b1;
                op_q         <= instr_opcode;
                opnd_q       <= instr_operand;
                kind_q       <= d_kind;
                alu_op_q     <= d_alu;
                cnt          <= d_cyc;
                instr_bytes  <= d_len;
                instr_cycles <= d_cyc;
                illegal      <= (d_kind == K_NONE);
                if (d_kind == K_MOVC) begin
                    code_addr <= sixteen_bit_pointer + {8'h00, acc};
                    code_rd   <= 1'b1;
                end
            end else if (busy) begin
                cnt <= cnt - 3'h1;
                if (last) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    case (kind_q)
                        K_ACC: begin
                            acc <= res;
                            if (alu_op_q == `CAID_ALU_DA) begin
                                psw[`CAID_PSW_CY] <= f_cy;
                            end else begin
                                psw[`CAID_PSW_CY] <= f_cy;
                                psw[`CAID_PSW_AC] <= f_ac;
                                psw[`CAID_PSW_OV] <= f_ov;
                            end
                        end
                        K_STEP: begin
                            if (lo == `CAID_LO_ACC_IMM) begin
                                acc <= res;
                            end else if (!eff_ram) begin
                                case (eff_addr)
                                    `CAID_SFR_ACC:    acc <= res;
                                    `CAID_SFR_B:      second_operand_reg <= res;
                                    `CAID_SFR_PSW:    psw <= res;
                                    `CAID_SFR_PTR_LO: sixteen_bit_pointer[7:0] <= res;
                                    `CAID_SFR_PTR_HI: sixteen_bit_pointer[15:8] <= res;
                                    default:          psw <= psw;
                                endcase
                            end
                        end
                        K_INCP: sixteen_bit_pointer <= sixteen_bit_pointer + 16'h0001;
                        K_MOVC: acc <= code_rdata;
                        K_B: begin
                            acc                <= res;
                            second_operand_reg <= res_b;
                            psw[`CAID_PSW_CY]  <= f_cy;
                            psw[`CAID_PSW_OV]  <= f_ov;
                        end
                        default: illegal <= illegal;
                    endcase
                end
            end else if (ld_go && ld_addr >= `CAID_SFR_BASE) begin
                case (ld_addr)
                    `CAID_SFR_ACC:    acc <= ld_data;
                    `CAID_SFR_B:      second_operand_reg <= ld_data;
                    `CAID_SFR_PSW:    psw <= ld_data;
                    `CAID_SFR_PTR_LO: sixteen_bit_pointer[7:0] <= ld_data;
                    `CAID_SFR_PTR_HI: sixteen_bit_pointer[15:8] <= ld_data;
                    default:          psw <= psw;
                endcase
            end
        end
    end
endmodule // caid_core
`default_nettype wire

// ===== verif/caid_core_chk.sv
// Port assertions of the arithmetic core
`timescale 1ns/1ns
`default_nettype none
`include "caid_map.vh"
module caid_core_chk (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        instr_valid,
    input wire logic [7:0]  instr_opcode,
    input wire logic [7:0]  instr_operand,
    input wire logic        busy,
    input wire logic        done,
    input wire logic [1:0]  instr_bytes,
    input wire logic [2:0]  instr_cycles,
    input wire logic [7:0]  acc,
    input wire logic [7:0]  second_operand_reg,
    input wire logic [7:0]  psw,
    input wire logic [15:0] sixteen_bit_pointer,
    input wire logic [15:0] code_addr,
    input wire logic        code_rd
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic       take;
    logic [3:0] run_len;
    assign take = instr_valid && !busy;
    // Busy cycle count
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) run_len <= 4'h0;
        else if (busy) run_len <= run_len + 4'h1;
        else run_len <= 4'h0;
    end
    function automatic logic [1:0] len_of(input logic [7:0] op);
        return (op[3:0] == 4'h5 && op[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9})
            || (op[3:0] == 4'h4 && op[7:4] inside {4'h2, 4'h3, 4'h9}) ? 2'h2 : 2'h1;
    endfunction
    function automatic logic [2:0] cyc_of(input logic [7:0] op);
        if (op == `CAID_OP_MUL) return `CAID_CYC_2;
        if (op == `CAID_OP_DIV) return `CAID_CYC_6;
        if (op == `CAID_OP_DA) return `CAID_CYC_3;
        if (op == `CAID_OP_MOVC_PTR) return `CAID_CYC_5;
        if (op[3:0] < 4'h4 || !(op[7:4] inside {4'h0, 4'h1, 4'h2, 4'h3, 4'h9})) return 3'h1;
        if (op[7:4] > 4'h1) return op[3] ? 3'h1 : 3'h2;
        return op[3] ? 3'h2 : (op[3:0] == 4'h4 ? 3'h1 : 3'h3);
    endfunction
    busy_length_a: assert property (done |-> run_len == {1'b0, instr_cycles})
        else $error("busy span wrong");
    byte_count_a: assert property (take |=> instr_bytes == len_of($past(instr_opcode)))
        else $error("byte length wrong");
    cycle_count_a: assert property (take |=> instr_cycles == cyc_of($past(instr_opcode)))
        else $error("cycle count wrong");
    mul_result_a: assert property (take && instr_opcode == `CAID_OP_MUL |-> ##3 done
        && {second_operand_reg, acc} == $past(acc, 3) * $past(second_operand_reg, 3))
        else $error("product wrong");
    div_result_a: assert property (take && instr_opcode == `CAID_OP_DIV
        && second_operand_reg != 8'h00 |-> ##7 done && acc == $past(acc, 7) / $past(second_operand_reg, 7)
        && second_operand_reg == $past(acc, 7) % $past(second_operand_reg, 7))
        else $error("quotient wrong");
    div_zero_a: assert property (take && instr_opcode == `CAID_OP_DIV && second_operand_reg == 8'h00
        |-> ##7 done && !psw[`CAID_PSW_CY] && psw[`CAID_PSW_OV] && acc == $past(acc, 7))
        else $error("zero divide wrong");
    ptr_step_a: assert property (take && instr_opcode == `CAID_OP_INC_PTR |-> ##2
        sixteen_bit_pointer == $past(sixteen_bit_pointer, 2) + 16'h0001)
        else $error("pointer step wrong");
    index_read_a: assert property (take && instr_opcode == `CAID_OP_MOVC_PTR |=> code_rd
        && code_addr == $past(sixteen_bit_pointer) + {8'h00, $past(acc)})
        else $error("indexed address wrong");
    imm_add_a: assert property (take && instr_opcode == 8'h24 |-> ##3
        acc == $past(acc, 3) + $past(instr_operand, 3))
        else $error("immediate add wrong");
    carry_add_a: assert property (take && instr_opcode == 8'h34 |-> ##3
        acc == $past(acc, 3) + $past(instr_operand, 3) + {7'h00, $past(psw[`CAID_PSW_CY], 3)})
        else $error("add with carry wrong");
    acc_step_a: assert property (take && (instr_opcode == 8'h04 || instr_opcode == 8'h14) |-> ##2
        acc == $past(acc, 2) + ($past(instr_opcode[4], 2) ? 8'hFF : 8'h01))
        else $error("acc step wrong");
    cover property (take && instr_opcode == `CAID_OP_DIV);
    cover property (done && take);
    cover property (code_rd);
endmodule // caid_core_chk
bind caid_core caid_core_chk u_chk (.*);
`default_nettype wire

// ===== verif/caid_code_mem.sv
// Program memory model answering indexed reads
`timescale 1ns/1ns
`default_nettype none
module caid_code_mem (
    input wire logic        ref_clk,
    input wire logic        code_rd,
    input wire logic        done,
    input wire logic [15:0] code_addr,
    output var logic [7:0]  code_rdata
);
    logic       hold = 1'b0;
    logic [7:0] junk = 8'hA5;
    // Byte valid from after the strobe until done, noise otherwise
    always @(posedge ref_clk) begin
        junk <= junk + 8'h35;
        if (code_rd) begin
            hold <= 1'b1;
            code_rdata <= code_addr[7:0] ^ code_addr[15:8] ^ 8'h5A;
        end else if (done || !hold) begin
            hold <= 1'b0;
            code_rdata <= junk;
        end
    end
endmodule // caid_code_mem
`default_nettype wire

// ===== verif/cpu_arith_instr_decode_tb.sv
// Self-checking bench of the arithmetic core
`timescale 1ns/1ns
`default_nettype none
`include "caid_map.vh"
module cpu_arith_instr_decode_tb;
    logic        ref_clk, rst_n, instr_valid, ld_we, busy, done, illegal, code_rd, bit_val;
    logic [7:0]  instr_opcode, instr_operand, ld_addr, ld_data, code_rdata, bit_addr;
    logic [7:0]  acc, second_operand_reg, psw;
    logic [1:0]  instr_bytes;
    logic [2:0]  instr_cycles;
    logic [15:0] sixteen_bit_pointer, code_addr;
    int          errors, cmp_count;

    caid_core DUT (.*);
    caid_code_mem u_mem (.*);

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask

    task automatic ld(input logic [7:0] a, input logic [7:0] d);
        ld_addr = a;
        ld_data = d;
        ld_we = 1'b1;
        @(posedge ref_clk) #1;
    endtask

    // One instruction, checked for length and timing
    task automatic run(input logic [7:0] op, input logic [7:0] opnd, input logic [1:0] eb,
                       input logic [2:0] ec);
        int k;
        ld_we = 1'b0;
        instr_opcode = op;
        instr_operand = opnd;
        instr_valid = 1'b1;
        @(posedge ref_clk) #1;
        instr_valid = 1'b0;
        chk({10'h000, illegal, instr_bytes, instr_cycles}, {10'h000, ~|op, eb, ec});
        k = 1;
        while (done !== 1'b1 && k < 20) begin
            @(posedge ref_clk) #1;
            k++;
        end
        if (k >= 20) begin
            errors++;
            end_of_test();
        end
        chk(k[15:0], {13'h0000, ec} + 16'h0001);
    endtask

    // Bank 1, R0 points at 0x40; bank 0 R0 is a decoy
    task automatic prep(input logic [7:0] a, input logic [7:0] p);
        ld(`CAID_SFR_ACC, a);
        ld(`CAID_SFR_PSW, p);
        ld(8'h08, 8'h40);
        ld(8'h00, 8'h99);
        ld(8'h40, 8'h11);
        ld(8'h30, 8'h22);
    endtask

    task automatic t_alu;
        logic [3:0] hi [3] = '{`CAID_HI_ADD, `CAID_HI_SUM_WITH_CARRY, `CAID_HI_DIFFERENCE_WITH_BORROW};
        logic [7:0] s;
        logic [8:0] r;
        logic       c, sub, ac, ov;
        for (int g = 0; g < 3; g++) begin
            for (int f = 0; f < 4; f++) begin
                s = f == 0 ? 8'h33 : f == 1 ? 8'h22 : f == 2 ? 8'h11 : 8'h40;
                c = g != 0;
                sub = g == 2;
                prep(8'hC8, 8'h88);
                run({hi[g], f == 3 ? 4'h8 : 4'h4 + f[3:0]}, f == 1 ? 8'h30 : 8'h33,
                    f < 2 ? 2'h2 : 2'h1, f == 3 ? 3'h1 : 3'h2);
                r = sub ? 9'h0C8 - {1'b0, s} - {8'h00, c} : 9'h0C8 + {1'b0, s} + {8'h00, c};
                ac = sub ? (5'h08 < {1'b0, s[3:0]} + {4'h0, c})
                         : (5'h08 + {1'b0, s[3:0]} + {4'h0, c} > 5'h0F);
                ov = ((1'b1 ^ s[7]) == sub) && (r[7] != 1'b1);
                chk({5'h00, acc, psw[7], psw[6], psw[2]}, {5'h00, r[7:0], r[8], ac, ov});
            end
        end
        $display("Arith test done");
    endtask

    task automatic t_step;
        logic [7:0] base;
        for (int g = 0; g < 2; g++) begin
            for (int f = 0; f < 4; f++) begin
                base = f == 0 ? 8'h7F : f == 1 ? 8'h22 : f == 2 ? 8'h11 : 8'h40;
                prep(8'h7F, 8'h08);
                run({g ? `CAID_HI_DEC : `CAID_HI_INC, f == 3 ? 4'h8 : 4'h4 + f[3:0]}, 8'h30,
                    f == 1 ? 2'h2 : 2'h1, f == 0 ? 3'h1 : f == 3 ? 3'h2 : 3'h3);
                chk({8'h00, psw}, 16'h0008);
                if (f != 0) begin
                    ld(`CAID_SFR_ACC, 8'h00);
                    run({`CAID_HI_ADD, f == 3 ? 4'h8 : 4'h4 + f[3:0]}, 8'h30,
                        f == 1 ? 2'h2 : 2'h1, f == 3 ? 3'h1 : 3'h2);
                end
                chk({8'h00, acc}, {8'h00, base + (g ? 8'hFF : 8'h01)});
            end
        end
        $display("Step test done");
    endtask

    task automatic t_misc;
        prep(8'h50, 8'h08);
        ld(`CAID_SFR_B, 8'h0A);
        run(`CAID_OP_MUL, 8'h00, 2'h1, 3'h2);
        chk({second_operand_reg, acc}, 16'h0320);
        ld(`CAID_SFR_ACC, 8'hFB);
        ld(`CAID_SFR_B, 8'h10);
        run(`CAID_OP_DIV, 8'h00, 2'h1, 3'h6);
        chk({second_operand_reg, acc}, 16'h0B0F);
        ld(`CAID_SFR_B, 8'h00);
        ld(`CAID_SFR_PSW, 8'h80);
        run(`CAID_OP_DIV, 8'h00, 2'h1, 3'h6);
        chk({6'h00, acc, psw[7], psw[2]}, {6'h00, 8'h0F, 1'b0, 1'b1});
        run(8'h15, `CAID_SFR_PTR_LO, 2'h2, 3'h3);
        ld(`CAID_SFR_PTR_HI, 8'h12);
        ld(`CAID_SFR_ACC, 8'h3C);
        ld(`CAID_SFR_PSW, 8'h00);
        run(`CAID_OP_INC_PTR, 8'h00, 2'h1, 3'h1);
        run(8'h00, 8'h00, 2'h1, 3'h1);
        run(`CAID_OP_DA, 8'h00, 2'h1, 3'h3);
        chk(sixteen_bit_pointer, 16'h1300);
        chk({8'h00, acc}, 16'h0042);
        $display("Misc test done");
    endtask

    task automatic t_index;
        logic [7:0] ba [3] = '{8'h03, 8'h02, 8'hE2};
        logic       bv [3] = '{1'b1, 1'b0, 1'b1};
        ld(`CAID_SFR_PTR_LO, 8'h34);
        ld(`CAID_SFR_PTR_HI, 8'h12);
        ld(`CAID_SFR_ACC, 8'hF0);
        run(`CAID_OP_MOVC_PTR, 8'h00, 2'h1, 3'h5);
        chk({8'h00, acc}, {8'h00, 8'h24 ^ 8'h13 ^ 8'h5A});
        ld(`CAID_SFR_ACC, 8'h04);
        ld(8'h20, 8'h08);
        for (int i = 0; i < 3; i++) begin
            bit_addr = ba[i];
            @(posedge ref_clk) #1;
            @(posedge ref_clk) #1;
            chk({15'h0000, bit_val}, {15'h0000, bv[i]});
        end
        $display("Index test done");
    endtask

    initial begin
        errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        instr_valid = 1'b0;
        ld_we = 1'b0;
        instr_opcode = 8'h00;
        instr_operand = 8'h00;
        ld_addr = 8'h00;
        ld_data = 8'h00;
        bit_addr = 8'h00;
        repeat (2) @(posedge ref_clk);
        #1 rst_n = 1'b1;
        t_alu();
        t_step();
        t_misc();
        t_index();
        end_of_test();
    end
endmodule // cpu_arith_instr_decode_tb
`default_nettype wire
